/* hdl/hpu_host_port.sv */
// Host port unit: host side registers, data paths, requests, core interrupts
`timescale 1ns/1ps
// Contract
// - Enabled host-caused status flag raises internal core interrupt, no pin.
// - Three core interrupts: receive full, transmit empty, host command.
// - Core read/write clears data interrupts; core acknowledge clears command pending.
// - Host addresses 0..3 are control, command, status, vector; 4,5 read zero.
// - Little endian puts high byte at 7; big endian at 6.
// - Interface control register is host read/write only, core cannot reach it.
// - Receive enable drives request pin while host receive full.
// - Transmit enable drives request pin while host transmit empty.
// - Split bit makes request pin transmit-only and acknowledge pin receive-only.
// - Host sets two flags, mirrored to core status, core cannot change them.
// - Hardware reset clears enable, split, flag and endian control bits.
// - Host writing init bit runs local initialise, bit then self-clears.
// - Initialise action per enables: receive path, transmit path, both, or none.
// - In core stop mode host pins are disconnected, configuration kept.
// - Host writes command vector to pick one of 128 core routines.
// - Separate double-buffered transmit and receive paths.
// - Host transmit pair moves to core receive word when the pair is full and the core word is free.
// - Core transmit word moves to host receive pair when the core word is full and the pair is free.
// - Reading the final-address receive byte clears host receive full.
// - Writing the final-address transmit byte clears host transmit empty.
module hpu_host_port
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic HOST_CS_N,
    input wire logic HOST_RD_N,
    input wire logic HOST_WR_N,
    input wire logic [2:0] HOST_ADDR,
    input wire logic [7:0] HOST_DATA_IN,
    output logic [7:0] HOST_DATA_OUT,
    output logic HOST_DATA_OE,
    output logic REQ_PIN_N_OUT,
    output logic REQ_PIN_OE,
    input wire logic ACK_PIN_N_IN,
    output logic ACK_PIN_N_OUT,
    output logic ACK_PIN_OE,
    input wire logic CORE_STOP,
    input wire logic CORE_RX_IRQ_EN,
    input wire logic CORE_TX_IRQ_EN,
    input wire logic CORE_CMD_IRQ_EN,
    input wire logic [1:0] CORE_FLAGS_TO_HOST,
    input wire logic CORE_RX_READ,
    output logic [15:0] CORE_RX_WORD,
    input wire logic CORE_TX_WRITE,
    input wire logic [15:0] CORE_TX_WORD,
    input wire logic CORE_CMD_ACK,
    output logic [6:0] CORE_CMD_VECTOR,
    output logic CORE_RECEIVE_FULL,
    output logic CORE_TRANSMIT_EMPTY,
    output logic CORE_CMD_PENDING,
    output logic [1:0] CORE_HOST_FLAGS,
    output logic CORE_IRQ_RX,
    output logic CORE_IRQ_TX,
    output logic CORE_IRQ_CMD
);
    import hpu_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    hpu_strobe_if acc ();
    logic [7:0] ctl_r;
    logic [7:0] ctl_nxt;
    logic [6:0] hv_r;
    logic [6:0] hv_nxt;
    logic hc_r;
    logic hc_nxt;
    logic [7:0] ivr_r;
    logic [7:0] ivr_nxt;
    logic [15:0] host_tx_r;
    logic [15:0] host_tx_nxt;
    logic [15:0] host_rx_r;
    logic [15:0] host_rx_nxt;
    logic [15:0] core_rx_r;
    logic [15:0] core_rx_nxt;
    logic [15:0] core_tx_r;
    logic [15:0] core_tx_nxt;
    logic host_rx_full_r;
    logic host_rx_full_nxt;
    logic host_tx_empty_r;
    logic host_tx_empty_nxt;
    logic core_rx_full_r;
    logic core_rx_full_nxt;
    logic core_tx_empty_r;
    logic core_tx_empty_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic oe_r;
    logic oe_nxt;
    logic to_core;
    logic to_host;
    logic req_rx;
    logic req_tx;
    logic req_any;
    logic [1:0] ack_sync_r;
    logic [1:0] ack_sync_nxt;
    logic vector_cycle;
    logic [7:0] status;

    // True when a data address holds the high byte under the given order
    function automatic logic is_high_byte(input logic [2:0] a, input logic little);
        is_high_byte = little ? (a == ADDR_DATA_SECOND) : (a == ADDR_DATA_FIRST);
    endfunction
    // ************************************************************
    // Host strobe synchroniser
    // ************************************************************
    // two-stage strobe sync
    hpu_strobe_sync u_sync
    (
        .clk(CLOCK),
        .rst(SYS_RST),
        .block(CORE_STOP),
        .cs_n(HOST_CS_N),
        .rd_n(HOST_RD_N),
        .wr_n(HOST_WR_N),
        .addr(HOST_ADDR),
        .wdata(HOST_DATA_IN),
        .acc(acc.sync)
    );

    // ************************************************************
    // Request logic and status
    // ************************************************************
    always_comb
    begin
        req_rx = ctl_r[CTL_RX_REQ_EN] & host_rx_full_r;
        req_tx = ctl_r[CTL_TX_REQ_EN] & host_tx_empty_r;
        req_any = req_rx | req_tx;
        // Vector fetch only with combined request and acknowledge
        vector_cycle = ~ctl_r[CTL_SPLIT_REQ] & req_any & ~ack_sync_r[1];
        status = 8'h00;
        status[STS_RX_FULL] = host_rx_full_r;
        status[STS_TX_EMPTY] = host_tx_empty_r;
        status[STS_TX_READY] = host_tx_empty_r & ~core_rx_full_r;
        status[STS_CORE_FLAG_LO] = CORE_FLAGS_TO_HOST[0];
        status[STS_CORE_FLAG_HI] = CORE_FLAGS_TO_HOST[1];
        status[STS_REQUEST] = req_any;
    end

    // ************************************************************
    // Host registers and data paths: next values
    // ************************************************************
    always_comb
    begin
        ctl_nxt = ctl_r;
        hv_nxt = hv_r;
        hc_nxt = hc_r;
        ivr_nxt = ivr_r;
        host_tx_nxt = host_tx_r;
        host_rx_nxt = host_rx_r;
        core_rx_nxt = core_rx_r;
        core_tx_nxt = core_tx_r;
        host_rx_full_nxt = host_rx_full_r;
        host_tx_empty_nxt = host_tx_empty_r;
        core_rx_full_nxt = core_rx_full_r;
        core_tx_empty_nxt = core_tx_empty_r;

        if (ctl_r[CTL_INIT])
        begin
            ctl_nxt[CTL_INIT] = 1'b0;
            if (ctl_r[CTL_RX_REQ_EN])
            begin
                host_rx_full_nxt = 1'b0;
                core_tx_empty_nxt = 1'b1;
            end
            if (ctl_r[CTL_TX_REQ_EN])
            begin
                host_tx_empty_nxt = 1'b1;
                core_rx_full_nxt = 1'b0;
            end
        end

        if (CORE_RX_READ)
            core_rx_full_nxt = 1'b0;
        if (CORE_TX_WRITE)
        begin
            core_tx_nxt = CORE_TX_WORD;
            core_tx_empty_nxt = 1'b0;
        end
        if (CORE_CMD_ACK)
            hc_nxt = 1'b0;

        // final receive byte read clears full
        if (acc.rd_done && !vector_cycle && acc.addr == ADDR_DATA_SECOND)
            host_rx_full_nxt = 1'b0;

        if (acc.wr_done)
        begin
            case (acc.addr)
                ADDR_CONTROL:
                    ctl_nxt = acc.wdata & CTL_WRITE_MASK;
                ADDR_CMD_VECTOR:
                begin
                    hv_nxt = acc.wdata[6:0];
                    if (acc.wdata[CMD_PENDING_BIT])
                        hc_nxt = 1'b1;
                end
                ADDR_INT_VECTOR:
                    ivr_nxt = acc.wdata;
                ADDR_DATA_FIRST, ADDR_DATA_SECOND:
                begin
                    if (is_high_byte(acc.addr, ctl_r[CTL_LITTLE_END]))
                        host_tx_nxt[15:8] = acc.wdata;
                    else
                        host_tx_nxt[7:0] = acc.wdata;
                    if (acc.addr == ADDR_DATA_SECOND)
                        host_tx_empty_nxt = 1'b0;
                end
                default:
                    ivr_nxt = ivr_r;
            endcase
        end
        to_core = ~host_tx_empty_r & ~core_rx_full_r;
        if (to_core)
        begin
            core_rx_nxt = host_tx_r;
            host_tx_empty_nxt = 1'b1;
            core_rx_full_nxt = 1'b1;
        end
        to_host = ~core_tx_empty_r & ~host_rx_full_r;
        if (to_host)
        begin
            host_rx_nxt = core_tx_r;
            host_rx_full_nxt = 1'b1;
            core_tx_empty_nxt = 1'b1;
        end
    end

    // ************************************************************
    // Host registers and data paths: storage
    // ************************************************************
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            ctl_r <= CONTROL_RESET;
            hv_r <= CMD_VECTOR_RESET;
            hc_r <= 1'b0;
            ivr_r <= INT_VECTOR_RESET;
            host_tx_r <= 16'h0000;
            host_rx_r <= 16'h0000;
            core_rx_r <= 16'h0000;
            core_tx_r <= 16'h0000;
            host_rx_full_r <= HOST_RX_FULL_RESET;
            host_tx_empty_r <= HOST_TX_EMPTY_RESET;
            core_rx_full_r <= CORE_RX_FULL_RESET;
            core_tx_empty_r <= CORE_TX_EMPTY_RESET;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            hv_r <= hv_nxt;
            hc_r <= hc_nxt;
            ivr_r <= ivr_nxt;
            host_tx_r <= host_tx_nxt;
            host_rx_r <= host_rx_nxt;
            core_rx_r <= core_rx_nxt;
            core_tx_r <= core_tx_nxt;
            host_rx_full_r <= host_rx_full_nxt;
            host_tx_empty_r <= host_tx_empty_nxt;
            core_rx_full_r <= core_rx_full_nxt;
            core_tx_empty_r <= core_tx_empty_nxt;
        end
    end

    // ************************************************************
    // Host read data: next values
    // ************************************************************
    always_comb
    begin
        rdata_nxt = 8'h00;
        oe_nxt = acc.rd_active;
        ack_sync_nxt = {ack_sync_r[0], ACK_PIN_N_IN}; // Two flops on acknowledge pin
        if (vector_cycle)
            rdata_nxt = ivr_r;
        else
        begin
            case (acc.addr)
                ADDR_CONTROL:
                    rdata_nxt = ctl_r;
                ADDR_CMD_VECTOR:
                    rdata_nxt = {hc_r, hv_r};
                ADDR_STATUS:
                    rdata_nxt = status;
                ADDR_INT_VECTOR:
                    rdata_nxt = ivr_r;
                ADDR_DATA_FIRST, ADDR_DATA_SECOND:
                    rdata_nxt = is_high_byte(acc.addr, ctl_r[CTL_LITTLE_END]) ?
                        host_rx_r[15:8] : host_rx_r[7:0];
                default:
                    rdata_nxt = 8'h00;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            rdata_r <= 8'h00;
            oe_r <= 1'b0;
            ack_sync_r <= 2'h3;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            oe_r <= oe_nxt;
            ack_sync_r <= ack_sync_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Host bus drive
    assign HOST_DATA_OUT = rdata_r;
    assign HOST_DATA_OE = oe_r & ~CORE_STOP;

    assign REQ_PIN_N_OUT = ctl_r[CTL_SPLIT_REQ] ? ~req_tx : ~req_any;
    assign REQ_PIN_OE = ~CORE_STOP;
    assign ACK_PIN_N_OUT = ~req_rx;
    assign ACK_PIN_OE = ctl_r[CTL_SPLIT_REQ] & ~CORE_STOP;

    // Core side view
    assign CORE_RX_WORD = core_rx_r;
    assign CORE_CMD_VECTOR = hv_r;
    assign CORE_RECEIVE_FULL = core_rx_full_r;
    assign CORE_TRANSMIT_EMPTY = core_tx_empty_r;
    assign CORE_CMD_PENDING = hc_r;
    assign CORE_HOST_FLAGS = {ctl_r[CTL_FLAG_ONE], ctl_r[CTL_FLAG_ZERO]};

    assign CORE_IRQ_RX = core_rx_full_r & CORE_RX_IRQ_EN;
    assign CORE_IRQ_TX = core_tx_empty_r & CORE_TX_IRQ_EN;
    assign CORE_IRQ_CMD = hc_r & CORE_CMD_IRQ_EN;
endmodule

/* hdl/hpu_pkg.sv */
// Package of host port constants: map, field positions, reset values
package hpu_pkg;
    // ************************************************************
    // Host side byte addresses
    // ************************************************************
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_CMD_VECTOR = 3'h1;
    localparam logic [2:0] ADDR_STATUS = 3'h2;
    localparam logic [2:0] ADDR_INT_VECTOR = 3'h3;
    localparam logic [2:0] ADDR_UNUSED_A = 3'h4;
    localparam logic [2:0] ADDR_UNUSED_B = 3'h5;
    localparam logic [2:0] ADDR_DATA_FIRST = 3'h6;
    localparam logic [2:0] ADDR_DATA_SECOND = 3'h7;

    // ************************************************************
    // Interface control field positions
    // ************************************************************
    localparam int CTL_RX_REQ_EN = 0;
    localparam int CTL_TX_REQ_EN = 1;
    localparam int CTL_SPLIT_REQ = 2;
    localparam int CTL_FLAG_ZERO = 3;
    localparam int CTL_FLAG_ONE = 4;
    localparam int CTL_LITTLE_END = 5;
    localparam int CTL_INIT = 7;
    localparam logic [7:0] CTL_WRITE_MASK = 8'hbf;

    // ************************************************************
    // Status and command vector field positions
    // ************************************************************
    localparam int STS_RX_FULL = 0;
    localparam int STS_TX_EMPTY = 1;
    localparam int STS_TX_READY = 2;
    localparam int STS_CORE_FLAG_LO = 3;
    localparam int STS_CORE_FLAG_HI = 4;
    localparam int STS_REQUEST = 7;
    localparam int CMD_PENDING_BIT = 7;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [6:0] CMD_VECTOR_RESET = 7'h32;
    localparam logic [7:0] INT_VECTOR_RESET = 8'h00;
    localparam logic HOST_RX_FULL_RESET = 1'b0;
    localparam logic HOST_TX_EMPTY_RESET = 1'b1;
    localparam logic CORE_RX_FULL_RESET = 1'b0;
    localparam logic CORE_TX_EMPTY_RESET = 1'b1;
endpackage

/* hdl/hpu_strobe_if.sv */
// Interface carrying synchronised host accesses into the core domain
`timescale 1ns/1ps
interface hpu_strobe_if;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic rd_active;
    logic rd_done;
    logic wr_done;
    modport sync (output addr, output wdata, output rd_active, output rd_done, output wr_done);
    modport user (input addr, input wdata, input rd_active, input rd_done, input wr_done);
endinterface

/* hdl/hpu_strobe_sync.sv */
// Two-stage synchroniser and edge detector for host strobes
`timescale 1ns/1ps
module hpu_strobe_sync
(
    input wire logic clk,
    input wire logic rst,
    input wire logic block,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    hpu_strobe_if.sync acc
);
    import hpu_pkg::*;

    logic [13:0] meta_r;
    logic [13:0] meta_nxt;
    logic [13:0] sync_r;
    logic [13:0] sync_nxt;
    logic [10:0] hold_r;
    logic [10:0] hold_nxt;
    logic live;
    logic rd_prev_r;
    logic rd_prev_nxt;
    logic wr_prev_r;
    logic wr_prev_nxt;
    logic rd_now;
    logic wr_now;

    // ************************************************************
    // Next values: meta stage feeds only the sync stage
    // ************************************************************
    always_comb
    begin
        // Raw pins only; strobes are combined after the second flop
        meta_nxt = {wdata, addr, cs_n, rd_n, wr_n};
        sync_nxt = meta_r;
        rd_now = ~(sync_r[2] | sync_r[1]) & ~block;
        wr_now = ~(sync_r[2] | sync_r[0]) & ~block;
        live = rd_now | wr_now;
        rd_prev_nxt = rd_now;
        wr_prev_nxt = wr_now;
        // Host may drop data with the strobe: keep the last active sample
        hold_nxt = live ? sync_r[13:3] : hold_r;
    end

    // Register stage
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= 14'h0007; // Strobes idle high
            sync_r <= 14'h0007;
            hold_r <= '0;
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            hold_r <= hold_nxt;
            rd_prev_r <= rd_prev_nxt;
            wr_prev_r <= wr_prev_nxt;
        end
    end

    // Access ends on strobe release, one pulse per access
    assign acc.addr = live ? sync_r[5:3] : hold_r[2:0];
    assign acc.wdata = live ? sync_r[13:6] : hold_r[10:3];
    assign acc.rd_active = rd_now;
    // Stop in mid access aborts it instead of completing it
    assign acc.rd_done = rd_prev_r & ~rd_now & ~block;
    assign acc.wr_done = wr_prev_r & ~wr_now & ~block;
endmodule

/* verif/hpu_host_port_sva.sv */
// Checker on the host port unit's pins and core-side outputs
`timescale 1ns/1ps
module hpu_host_port_sva
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic HOST_DATA_OE,
    input wire logic REQ_PIN_OE,
    input wire logic ACK_PIN_OE,
    input wire logic CORE_STOP,
    input wire logic CORE_RX_IRQ_EN,
    input wire logic CORE_TX_IRQ_EN,
    input wire logic CORE_CMD_IRQ_EN,
    input wire logic CORE_RX_READ,
    input wire logic CORE_TX_WRITE,
    input wire logic CORE_CMD_ACK,
    input wire logic CORE_RECEIVE_FULL,
    input wire logic CORE_TRANSMIT_EMPTY,
    input wire logic CORE_CMD_PENDING,
    input wire logic CORE_IRQ_RX,
    input wire logic CORE_IRQ_TX,
    input wire logic CORE_IRQ_CMD
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    // ********
    // Core interrupts and their clearing
    // ********
    rx_irq_match_a: assert property (CORE_IRQ_RX == (CORE_RECEIVE_FULL && CORE_RX_IRQ_EN))
        else $error("receive interrupt not flag and enable");
    tx_irq_match_a: assert property (CORE_IRQ_TX == (CORE_TRANSMIT_EMPTY && CORE_TX_IRQ_EN))
        else $error("transmit interrupt not flag and enable");
    cmd_irq_match_a: assert property (CORE_IRQ_CMD == (CORE_CMD_PENDING && CORE_CMD_IRQ_EN))
        else $error("command interrupt not flag and enable");
    cmd_ack_clear_a: assert property (CORE_CMD_ACK && CORE_CMD_PENDING |=> !CORE_CMD_PENDING)
        else $error("command pending kept after acknowledge");
    rx_read_clear_a: assert property (CORE_RX_READ && CORE_RECEIVE_FULL |=> !CORE_RECEIVE_FULL)
        else $error("receive full kept after core read");
    tx_write_clear_a: assert property (CORE_TX_WRITE && CORE_TRANSMIT_EMPTY |=> !CORE_TRANSMIT_EMPTY)
        else $error("transmit empty kept after core write");
    // ********
    // Stop mode isolation
    // ********
    stop_bus_off_a: assert property (CORE_STOP && $past(CORE_STOP) |-> !HOST_DATA_OE)
        else $error("data bus driven in stop mode");
    stop_pins_off_a: assert property (REQ_PIN_OE == !CORE_STOP && (!CORE_STOP || !ACK_PIN_OE))
        else $error("request pins driven in stop mode");
    cmd_ack_c: cover property (CORE_CMD_ACK && CORE_CMD_PENDING);
    rx_full_c: cover property ($rose(CORE_RECEIVE_FULL));
    stop_c: cover property (CORE_STOP);
endmodule

/* verif/hpu_host_model.sv */
// Host processor model: byte bus cycles and two-way pin levels
`timescale 1ns/1ps
module hpu_host_model
(
    input wire logic clk,
    output logic cs_n = 1'b1,
    output logic rd_n = 1'b1,
    output logic wr_n = 1'b1,
    output logic [2:0] addr = 3'h0,
    output logic [7:0] bus_in,
    input wire logic [7:0] bus_out,
    input wire logic bus_oe,
    output logic ack_n_in,
    input wire logic ack_n_out,
    input wire logic ack_oe
);
    logic drv = 1'b0;
    logic [7:0] dval = 8'h00;
    logic ack_low = 1'b0;
    // Wire level; a released bus shows the inverse of the last byte
    assign bus_in = drv ? dval : (bus_oe ? bus_out : ~dval);
    // Acknowledge idles high, device takes the pin in split mode
    assign ack_n_in = ack_oe ? ack_n_out : ~ack_low;
    // One cycle: strobe low 4 edges, read taken at the last, 6 idle
    // host model never commands stop mode
    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk);
        #1;
        addr = a;
        dval = d;
        drv = wr;
        cs_n = 1'b0;
        rd_n = wr;
        wr_n = !wr;
        repeat (4) @(posedge clk);
        q = bus_in;
        #1;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        drv = 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule

/* verif/hpu_host_port_bench.sv */
// Self-checking bench for the host port unit
`timescale 1ns/1ps
module hpu_host_port_bench;
    logic CLOCK = 1'b0;
    logic SYS_RST = 1'b1;
    logic CORE_STOP = 1'b0;
    logic CORE_RX_IRQ_EN = 1'b1;
    logic CORE_TX_IRQ_EN = 1'b1;
    logic CORE_CMD_IRQ_EN = 1'b1;
    logic [1:0] CORE_FLAGS_TO_HOST = 2'h1;
    logic CORE_RX_READ = 1'b0;
    logic CORE_TX_WRITE = 1'b0;
    logic [15:0] CORE_TX_WORD = 16'h0000;
    logic CORE_CMD_ACK = 1'b0;
    logic HOST_CS_N, HOST_RD_N, HOST_WR_N, ACK_PIN_N_IN, HOST_DATA_OE;
    logic REQ_PIN_N_OUT, REQ_PIN_OE, ACK_PIN_N_OUT, ACK_PIN_OE, CORE_RECEIVE_FULL;
    logic CORE_TRANSMIT_EMPTY, CORE_CMD_PENDING, CORE_IRQ_RX, CORE_IRQ_TX, CORE_IRQ_CMD;
    logic [2:0] HOST_ADDR;
    logic [7:0] HOST_DATA_IN, HOST_DATA_OUT, rd_q;
    logic [15:0] CORE_RX_WORD;
    logic [6:0] CORE_CMD_VECTOR;
    logic [1:0] CORE_HOST_FLAGS;
    logic [7:0] reset_map [6] = '{8'h00, 8'h32, 8'h0e, 8'h00, 8'h00, 8'h00};
    int fail_count = 0;
    int comparisons = 0;
    // 125 MHz core clock
    always #4 CLOCK = ~CLOCK;
    hpu_host_port hpu_host_port_inst
    (
        .CLOCK, .SYS_RST, .HOST_CS_N, .HOST_RD_N, .HOST_WR_N, .HOST_ADDR, .HOST_DATA_IN,
        .HOST_DATA_OUT, .HOST_DATA_OE, .REQ_PIN_N_OUT, .REQ_PIN_OE, .ACK_PIN_N_IN,
        .ACK_PIN_N_OUT, .ACK_PIN_OE, .CORE_STOP, .CORE_RX_IRQ_EN, .CORE_TX_IRQ_EN,
        .CORE_CMD_IRQ_EN, .CORE_FLAGS_TO_HOST, .CORE_RX_READ, .CORE_RX_WORD, .CORE_TX_WRITE,
        .CORE_TX_WORD, .CORE_CMD_ACK, .CORE_CMD_VECTOR, .CORE_RECEIVE_FULL,
        .CORE_TRANSMIT_EMPTY, .CORE_CMD_PENDING, .CORE_HOST_FLAGS, .CORE_IRQ_RX,
        .CORE_IRQ_TX, .CORE_IRQ_CMD
    );
    hpu_host_model hpu_host_model_inst
    (
        .clk(CLOCK), .cs_n(HOST_CS_N), .rd_n(HOST_RD_N), .wr_n(HOST_WR_N), .addr(HOST_ADDR),
        .bus_in(HOST_DATA_IN), .bus_out(HOST_DATA_OUT), .bus_oe(HOST_DATA_OE),
        .ack_n_in(ACK_PIN_N_IN), .ack_n_out(ACK_PIN_N_OUT), .ack_oe(ACK_PIN_OE)
    );
    // ********
    // Compare, bus and core tasks
    // ********
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hr(input logic [2:0] a, input logic [7:0] e);
        hpu_host_model_inst.access(1'b0, a, 8'h00, rd_q);
        chk(16'(rd_q), 16'(e));
    endtask
    task automatic hw(input logic [2:0] a, input logic [7:0] d);
        hpu_host_model_inst.access(1'b1, a, d, rd_q);
    endtask
    // Core pulse: 0 read receive word, 1 acknowledge command, 2 write word
    task automatic pulse(input int k);
        @(posedge CLOCK);
        #1;
        CORE_RX_READ = (k == 0);
        CORE_CMD_ACK = (k == 1);
        CORE_TX_WRITE = (k == 2);
        @(posedge CLOCK);
        #1;
        CORE_RX_READ = 1'b0;
        CORE_CMD_ACK = 1'b0;
        CORE_TX_WRITE = 1'b0;
        repeat (3) @(posedge CLOCK);
        #1;
    endtask
    task automatic finish_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge CLOCK);
        fail_count++;
        finish_test();
    end
    // Main sequence
    initial
    begin
        repeat (16) @(posedge CLOCK);
        #1;
        SYS_RST = 1'b0;
        for (int i = 0; i < 6; i++)
            hr(3'(i), reset_map[i]);
        // Host to core, big endian, second pair held back
        hw(3'h0, 8'h18);
        chk(16'(CORE_HOST_FLAGS), 16'h3);
        hw(3'h6, 8'ha1);
        hw(3'h7, 8'hb2);
        chk(CORE_RX_WORD, 16'ha1b2);
        hw(3'h6, 8'hc3);
        hw(3'h7, 8'hd4);
        hr(3'h2, 8'h08);
        pulse(0);
        chk(CORE_RX_WORD, 16'hc3d4);
        pulse(0);
        // Core to host, little endian
        hw(3'h0, 8'h20);
        chk(16'(CORE_HOST_FLAGS), 16'h0);
        CORE_TX_WORD = 16'h5a6b;
        pulse(2);
        hr(3'h6, 8'h6b);
        hr(3'h2, 8'h0f);
        hr(3'h7, 8'h5a);
        hr(3'h2, 8'h0e);
        // Request pins, combined then split
        hw(3'h0, 8'h02);
        chk(16'(REQ_PIN_N_OUT), 16'h0);
        hr(3'h2, 8'h8e);
        hw(3'h0, 8'h01);
        chk(16'(REQ_PIN_N_OUT), 16'h1);
        CORE_TX_WORD = 16'h1234;
        pulse(2);
        chk(16'(REQ_PIN_N_OUT), 16'h0);
        hw(3'h0, 8'h05);
        chk(16'(REQ_PIN_N_OUT), 16'h1);
        chk(16'(ACK_PIN_N_OUT), 16'h0);
        // Initialise both paths with every flag in the opposite state
        CORE_TX_IRQ_EN = 1'b0;
        CORE_TX_WORD = 16'h5678;
        pulse(2);
        repeat (2)
        begin
            hw(3'h6, 8'h11);
            hw(3'h7, 8'h22);
        end
        hw(3'h0, 8'h83);
        chk(16'(CORE_TRANSMIT_EMPTY), 16'h1);
        chk(16'(CORE_RECEIVE_FULL), 16'h0);
        hr(3'h0, 8'h03);
        hr(3'h2, 8'h8e);
        // Vector fetch: combined request pending and acknowledge low
        hw(3'h3, 8'h5c);
        hr(3'h3, 8'h5c);
        hpu_host_model_inst.ack_low = 1'b1;
        hr(3'h0, 8'h5c);
        hpu_host_model_inst.ack_low = 1'b0;
        // Host command with vector
        hw(3'h1, 8'hc5);
        chk(16'(CORE_CMD_PENDING), 16'h1);
        chk(16'(CORE_CMD_VECTOR), 16'h45);
        hr(3'h1, 8'hc5);
        pulse(1);
        chk(16'(CORE_CMD_PENDING), 16'h0);
        hr(3'h1, 8'h45);
        // Stop mode ignores the host and keeps the configuration
        CORE_STOP = 1'b1;
        hw(3'h0, 8'h18);
        chk(16'(CORE_HOST_FLAGS), 16'h0);
        CORE_STOP = 1'b0;
        hr(3'h0, 8'h03);
        finish_test();
    end
endmodule
bind hpu_host_port hpu_host_port_sva hpu_host_port_sva_inst
(
    .CLOCK, .SYS_RST, .HOST_DATA_OE, .REQ_PIN_OE, .ACK_PIN_OE, .CORE_STOP, .CORE_RX_IRQ_EN,
    .CORE_TX_IRQ_EN, .CORE_CMD_IRQ_EN, .CORE_RX_READ, .CORE_TX_WRITE, .CORE_CMD_ACK,
    .CORE_RECEIVE_FULL, .CORE_TRANSMIT_EMPTY, .CORE_CMD_PENDING, .CORE_IRQ_RX, .CORE_IRQ_TX,
    .CORE_IRQ_CMD
);
